//--- inc/pcs_pkg.sv
// constants shared by the program-counter, return-stack and indirect-address logic
// assumes a single core clock domain and an Avalon-MM register slave with byte addresses
package pcs_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int PAGE_W = 2;
  localparam int TGT_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int FSP_W = 8;
  localparam int IND_ADDR_W = 9;
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;
  localparam int BANK_BIT_POS = 7;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [BUS_AW-1:0] OFF_INDIRECT = 5'h00;
  localparam logic [BUS_AW-1:0] OFF_PC_LOW = 5'h04;
  localparam logic [BUS_AW-1:0] OFF_PC_LATCH = 5'h08;
  localparam logic [BUS_AW-1:0] OFF_FSP = 5'h0C;
  localparam logic [BUS_AW-1:0] OFF_BANK = 5'h10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [FSP_W-1:0] FSP_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic [BUS_DW-1:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [LOW_W-1:0] SELF_READ_VAL = 8'h00;
  localparam logic [PC_W-1:0] VECTOR_DEFAULT = 13'h0004;

endpackage

//--- logic/pcs_stack_mem.sv
// return-address storage: one write port and a registered read of the entry below the pointer
// assumes the owner presents the read address for the cycle after the current one
`timescale 1ns/1ps

module pcs_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13,
  parameter int AW = 3
) (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write slot
  input wire logic [WIDTH-1:0] wr_data, // value pushed
  input wire logic [AW-1:0] rd_addr, // slot that will be on top next cycle
  output logic [WIDTH-1:0] top_data // registered top entry
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // a push puts its value on top at once, bypassing the array
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      top_data <= '0;
    end else if (wr_en) begin
      top_data <= wr_data;
    end else begin
      top_data <= mem[rd_addr];
    end
  end

endmodule // pcs_stack_mem

//--- logic/pcs_core.sv
// program counter, paging latch, circular return stack and indirect data addressing
// assumes the decoder raises at most the operations it means in a cycle and that
// the register file answers an indirect read combinationally in the same cycle
`timescale 1ns/1ps

// Operation
// - counter is 13 bits, low byte readable/writable, upper bits written by software only through the latch
// - every reset clears the counter's upper bits
// - writing the low byte loads upper bits from latch bits 4:0 together
// - call and jump take 11 bits from instruction, top two from latch bits 4:3
// - eight-entry, 13-bit return stack outside memory, pointer hidden from software
// - call and interrupt vectoring push the counter onto the stack
// - all three returns pop and restore the whole 13-bit counter
// - pushes and pops never change the high latch
// - stack wraps circularly, ninth push overwrites the first entry
// - no overflow or underflow flag exists
// - indirect port is not stored, it accesses the register the pointer selects
// - reading the indirect port through itself returns zero
// - writing the indirect port through itself changes no register
// - indirect address is bank bit above the 8-bit file select pointer
module pcs_core
  import pcs_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR_ADDR = VECTOR_DEFAULT
) (
  input wire logic core_clk, // core clock, 50 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [BUS_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [BUS_DW-1:0] avs_writedata, // write data
  output logic [BUS_DW-1:0] avs_readdata, // registered read data
  output logic avs_waitrequest, // stall
  input wire logic op_step, // advance to next instruction
  input wire logic op_call, // call instruction
  input wire logic op_jump, // jump_instr
  input wire logic op_return, // return, return_with_literal or return_from_interrupt
  input wire logic op_vector, // interrupt branch to vector
  input wire logic [TGT_W-1:0] op_target, // instruction address field
  output logic [PC_W-1:0] pc_out, // fetch address
  output logic [IND_ADDR_W-1:0] ind_addr, // indirect target address
  output logic ind_rd, // indirect read strobe
  output logic ind_wr, // indirect write strobe
  output logic [LOW_W-1:0] ind_wdata, // indirect write data
  input wire logic [LOW_W-1:0] ind_rdata // indirect read data
);

  // ************************************************************
  // state
  // ************************************************************
  logic [PC_W-1:0] pc;
  logic [LATCH_W-1:0] pc_high_latch;
  logic [FSP_W-1:0] file_select_pointer;
  logic bank_pointer_bit;
  logic [PTR_W-1:0] stk_ptr;
  logic bus_ack;
  logic [LOW_W-1:0] wdata_q;
  logic [PC_W-1:0] stk_top;

  // ************************************************************
  // bus decode
  // ************************************************************
  // every access takes two cycles: the first samples data, the second completes
  wire bus_req = avs_read | avs_write;
  wire bus_first = bus_req & ~bus_ack;
  wire sel_ind = avs_address == OFF_INDIRECT;
  wire sel_low = avs_address == OFF_PC_LOW;
  wire sel_latch = avs_address == OFF_PC_LATCH;
  wire sel_fsp = avs_address == OFF_FSP;
  wire sel_bank = avs_address == OFF_BANK;
  wire wr_done = avs_write & bus_ack;
  wire wr_low = wr_done & sel_low;
  wire wr_latch = wr_done & sel_latch;
  wire wr_fsp = wr_done & sel_fsp;
  wire wr_bank = wr_done & sel_bank;
  wire ind_self = file_select_pointer == FSP_RST;

  assign avs_waitrequest = bus_req & ~bus_ack;

  // ************************************************************
  // indirect addressing
  // ************************************************************
  assign ind_addr = {bank_pointer_bit, file_select_pointer};
  assign ind_rd = avs_read & bus_first & sel_ind & ~ind_self;
  assign ind_wr = wr_done & sel_ind & ~ind_self;
  assign ind_wdata = wdata_q;

  wire [LOW_W-1:0] ind_value = ind_self ? SELF_READ_VAL : ind_rdata;
  wire [BUS_DW-1:0] rd_mux = sel_ind ? {{(BUS_DW-LOW_W){1'b0}}, ind_value} :
                             sel_low ? {{(BUS_DW-LOW_W){1'b0}}, pc[LOW_W-1:0]} :
                             sel_latch ? {{(BUS_DW-LATCH_W){1'b0}}, pc_high_latch} :
                             sel_fsp ? {{(BUS_DW-FSP_W){1'b0}}, file_select_pointer} :
                             sel_bank ? {{(BUS_DW-BANK_BIT_POS-1){1'b0}}, bank_pointer_bit,
                                         {BANK_BIT_POS{1'b0}}} :
                             BUS_ZERO;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_ack <= 1'b0;
      avs_readdata <= BUS_ZERO;
      wdata_q <= SELF_READ_VAL;
    end else begin
      bus_ack <= bus_first;
      if (bus_first) begin
        avs_readdata <= rd_mux;
        wdata_q <= avs_writedata[LOW_W-1:0];
      end
    end
  end

  // ************************************************************
  // counter sequencing
  // ************************************************************
  // a software write of the low byte outranks anything the decoder asks in that cycle
  wire dec_free = ~wr_low;
  wire do_ret = dec_free & op_return;
  wire do_vec = dec_free & ~op_return & op_vector;
  wire do_call = dec_free & ~op_return & ~op_vector & op_call;
  wire do_jump = dec_free & ~op_return & ~op_vector & ~op_call & op_jump;
  wire do_step = dec_free & ~op_return & ~op_vector & ~op_call & ~op_jump & op_step;
  wire do_push = do_call | do_vec;

  wire [PC_W-1:0] pc_inc = PC_W'(pc + 1'b1);
  wire [PC_W-1:0] pc_page = {pc_high_latch[LATCH_PAGE_HI:LATCH_PAGE_LO], op_target};
  wire [PC_W-1:0] pc_reload = {pc_high_latch, wdata_q};
  // a call returns past itself, an interrupt returns to the instruction it displaced
  wire [PC_W-1:0] push_data = do_vec ? pc : pc_inc;

  wire [PC_W-1:0] next_pc = wr_low ? pc_reload :
                            do_ret ? stk_top :
                            do_vec ? VECTOR_ADDR :
                            (do_call | do_jump) ? pc_page :
                            do_step ? pc_inc :
                            pc;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc <= PC_RST;
    end else begin
      pc <= next_pc;
    end
  end

  assign pc_out = pc;

  // ************************************************************
  // software registers
  // ************************************************************
  // the latch is only ever written by software, never by stack traffic
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_high_latch <= LATCH_RST;
      file_select_pointer <= FSP_RST;
      bank_pointer_bit <= 1'b0;
    end else begin
      if (wr_latch) begin
        pc_high_latch <= wdata_q[LATCH_W-1:0];
      end
      if (wr_fsp) begin
        file_select_pointer <= wdata_q;
      end
      if (wr_bank) begin
        bank_pointer_bit <= wdata_q[BANK_BIT_POS];
      end
    end
  end

  // ************************************************************
  // return stack
  // ************************************************************
  // pointer wraps freely and is never visible; no depth flag is kept
  wire [PTR_W-1:0] next_ptr = do_push ? PTR_W'(stk_ptr + 1'b1) :
                              do_ret ? PTR_W'(stk_ptr - 1'b1) :
                              stk_ptr;
  wire [PTR_W-1:0] next_top_addr = PTR_W'(next_ptr - 1'b1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stk_ptr <= PTR_RST;
    end else begin
      stk_ptr <= next_ptr;
    end
  end

  pcs_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W),
    .AW(PTR_W)
  ) u_stack (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wr_en(do_push),
    .wr_addr(stk_ptr),
    .wr_data(push_data),
    .rd_addr(next_top_addr),
    .top_data(stk_top)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_call;
    do_call;
  endsequence

  sequence s_ret_only;
    do_ret & ~do_push;
  endsequence

  sequence s_vec;
    do_vec;
  endsequence

  // a step out of an all-ones low byte is the only quiet way for the upper bits to move
  wire low_all_ones = &pc[LOW_W-1:0];

  chk_upper_reset: assert property (disable iff (1'b0) sys_rst |=> pc[PC_W-1:LOW_W] == '0)
    else $error("upper counter bits not cleared by reset");

  chk_low_write_load: assert property (wr_low |=> pc == {$past(pc_high_latch), $past(wdata_q)})
    else $error("low byte write did not load latch into upper bits");

  chk_jump_page: assert property (do_jump |=> pc == {$past(pc_high_latch[LATCH_PAGE_HI:LATCH_PAGE_LO]),
                                                    $past(op_target)})
    else $error("jump target not formed from latch page and target");

  chk_push_ptr: assert property (do_push |=> stk_ptr == $past(next_ptr) && stk_top == $past(push_data))
    else $error("push did not store counter on top");

  chk_call_return: assert property (s_call ##1 s_ret_only |=> pc == $past(pc_inc, 2))
    else $error("return did not restore address pushed by call");

  chk_latch_stable: assert property ((do_push | do_ret) & ~wr_latch |=> $stable(pc_high_latch))
    else $error("stack traffic changed the high latch");

  chk_stack_wrap: assert property (do_push & stk_ptr == PTR_W'(STACK_DEPTH - 1) |=> stk_ptr == PTR_RST)
    else $error("stack pointer did not wrap after eighth slot");

  chk_self_read: assert property (avs_read & bus_ack & sel_ind & $past(ind_self)
                                  |-> avs_readdata == BUS_ZERO)
    else $error("indirect self read returned nonzero");

  chk_self_write: assert property (avs_write & bus_ack & sel_ind & ind_self |-> ~ind_wr
                                   ##1 $stable({pc_high_latch, file_select_pointer, bank_pointer_bit}))
    else $error("indirect write through itself reached a register");

  chk_step_inc: assert property (do_step |=> pc == $past(pc_inc) && $stable(pc_high_latch))
    else $error("step did not increment full counter");

  chk_upper_hold: assert property (~(wr_low | do_ret | do_vec | do_call | do_jump) & ~(do_step & low_all_ones)
                                   |=> $stable(pc[PC_W-1:LOW_W]))
    else $error("upper counter bits moved without a reload");

  chk_call_page: assert property (do_call |=> pc == {$past(pc_high_latch[LATCH_PAGE_HI:LATCH_PAGE_LO]),
                                                    $past(op_target)})
    else $error("call target not formed from latch page and target");

  chk_vector_push: assert property (do_vec |=> pc == VECTOR_ADDR && stk_top == $past(pc))
    else $error("vector entry did not push the displaced counter");

  // pairs on adjacent edges: the pop must see the entry pushed one cycle earlier
  chk_vector_return: assert property (s_vec ##1 s_ret_only |=> pc == $past(pc, 2))
    else $error("return did not restore counter displaced by vector");

  chk_pop_restore: assert property (do_ret |=> pc == $past(stk_top))
    else $error("return did not load the popped entry");

  chk_pop_ptr: assert property (do_ret |=> stk_ptr == PTR_W'($past(stk_ptr) - 1'b1))
    else $error("pop did not step the stack pointer back");

  chk_ptr_hold: assert property (~do_push & ~do_ret |=> $stable(stk_ptr))
    else $error("hidden stack pointer moved without stack traffic");

  // register bus: every access answers on its second cycle
  chk_bus_answer: assert property (avs_waitrequest |=> ~avs_waitrequest)
    else $error("bus stalled for more than one cycle");

  chk_low_read: assert property (avs_read & bus_ack & sel_low |-> avs_readdata == BUS_DW'($past(pc[LOW_W-1:0])))
    else $error("low byte read did not return counter bits");

  chk_ind_read_data: assert property (avs_read & bus_ack & sel_ind & ~$past(ind_self)
                                      |-> avs_readdata == BUS_DW'($past(ind_rdata)))
    else $error("indirect read did not return the selected register");

  chk_self_strobe: assert property (avs_read & sel_ind & ind_self |-> ~ind_rd)
    else $error("indirect read through itself reached the register file");

  chk_bank_addr: assert property (wr_bank |=> ind_addr[IND_ADDR_W-1] == $past(wdata_q[BANK_BIT_POS]))
    else $error("bank bit not at top of indirect address");

  chk_fsp_addr: assert property (wr_fsp |=> ind_addr[FSP_W-1:0] == $past(wdata_q))
    else $error("pointer not at bottom of indirect address");

  // stray bus traffic to an unmapped offset must reach nothing
  chk_unmapped_write: assert property (wr_done & ~(sel_ind | sel_low | sel_latch | sel_fsp | sel_bank)
                                       |=> $stable({pc_high_latch, file_select_pointer, bank_pointer_bit}))
    else $error("unmapped write changed a register");

endmodule // pcs_core

//--- tb/pcs_regfile_model.sv
// register file model that answers the core's indirect accesses
// assumes strobes and address are settled at each rising edge
`timescale 1ns/1ps

module pcs_regfile_model
  import pcs_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic [IND_ADDR_W-1:0] ind_addr, // target address
  input wire logic ind_rd, // read strobe
  input wire logic ind_wr, // write strobe
  input wire logic [LOW_W-1:0] ind_wdata, // write data
  output logic [LOW_W-1:0] ind_rdata // read data
);
  logic [LOW_W-1:0] mem [0:2**IND_ADDR_W-1];
  // outside a read strobe the inverse shows, so a late capture cannot pass
  assign ind_rdata = ind_rd ? mem[ind_addr] : ~mem[ind_addr];
  always_ff @(posedge core_clk) begin
    if (ind_wr) begin
      mem[ind_addr] <= ind_wdata;
    end
  end
endmodule // pcs_regfile_model

//--- tb/pcs_core_bench.sv
// self-checking bench for pcs_core with a register file model on the indirect port
// assumes pcs_pkg, pcs_stack_mem and the model are compiled first
`timescale 1ns/1ps

module pcs_core_bench;
  import pcs_pkg::*;
  localparam logic [4:0] STEP = 5'h10, CALL = 5'h08, JUMP = 5'h04, RET = 5'h02, VEC = 5'h01;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [BUS_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BUS_DW-1:0] avs_writedata = '0;
  logic [BUS_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] ops = '0;
  logic [TGT_W-1:0] op_target = '0;
  logic [PC_W-1:0] pc_out;
  logic [IND_ADDR_W-1:0] ind_addr;
  logic ind_rd;
  logic ind_wr;
  logic [LOW_W-1:0] ind_wdata;
  logic [LOW_W-1:0] ind_rdata;
  int bad_count = 0;
  int checks_done = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int sp = 0;
  logic [15:0] rnd = 16'hDB1F;
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] stk [0:STACK_DEPTH-1];
  logic [31:0] rdv;
  logic [LATCH_W-1:0] lat;
  logic [7:0] ptr;

  pcs_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .op_step(ops[4]),
    .op_call(ops[3]), .op_jump(ops[2]), .op_return(ops[1]), .op_vector(ops[0]),
    .op_target(op_target), .pc_out(pc_out), .ind_addr(ind_addr), .ind_rd(ind_rd),
    .ind_wr(ind_wr), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));
  pcs_regfile_model rf (.core_clk(core_clk), .ind_addr(ind_addr), .ind_rd(ind_rd),
    .ind_wr(ind_wr), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [PC_W-1:0] paged(input logic [LATCH_W-1:0] l, input logic [TGT_W-1:0] t);
    return {l[LATCH_PAGE_HI:LATCH_PAGE_LO], t};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // waits on waitrequest only; the watchdog ends a hung access
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic do_op(input logic [4:0] o, input logic [TGT_W-1:0] t);
    @(posedge core_clk);
    ops <= o;
    op_target <= t;
    @(posedge core_clk);
    ops <= 5'h00;
    @(negedge core_clk);
  endtask
  // two ops on adjacent edges, so a pop meets the entry pushed one cycle before
  task automatic op_pair(input logic [4:0] o1, input logic [4:0] o2, input logic [TGT_W-1:0] t);
    @(posedge core_clk);
    ops <= o1;
    op_target <= t;
    @(posedge core_clk);
    ops <= o2;
    @(posedge core_clk);
    ops <= 5'h00;
    @(negedge core_clk);
  endtask
  task report_and_stop;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (ind_rd === 1'b1) rd_cnt++;
    if (ind_wr === 1'b1) wr_cnt++;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    report_and_stop;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    cmp(32'(pc_out), 32'h0000_0000, "pc after reset");
    rnd = lfsr(rnd);
    lat = {2'b00, rnd[2:0]};
    bus(1'b1, OFF_PC_LATCH, {3'h0, lat});
    bus(1'b1, OFF_PC_LOW, 8'hFE);
    @(negedge core_clk);
    exp_pc = {lat, 8'hFE};
    cmp(32'(pc_out), 32'(exp_pc), "low byte write");
    bus(1'b0, OFF_PC_LOW, 8'h00);
    cmp(rdv, 32'h0000_00FE, "low byte read");
    do_op(STEP, '0);
    do_op(STEP, '0);
    exp_pc = exp_pc + 13'h0002;
    cmp(32'(pc_out), 32'(exp_pc), "step carry");
    repeat (4) begin
      rnd = lfsr(rnd);
      do_op(JUMP, rnd[10:0]);
      exp_pc = paged(lat, rnd[10:0]);
      cmp(32'(pc_out), 32'(exp_pc), "jump");
    end
    // nine calls wrap the eight slots; the first entry is lost
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      stk[sp] = exp_pc + 13'h0001;
      sp = (sp + 1) % STACK_DEPTH;
      do_op(CALL, rnd[10:0]);
      exp_pc = paged(lat, rnd[10:0]);
      cmp(32'(pc_out), 32'(exp_pc), "call");
    end
    for (int i = 0; i < 8; i++) begin
      sp = (sp + STACK_DEPTH - 1) % STACK_DEPTH;
      do_op(RET, '0);
      exp_pc = stk[sp];
      cmp(32'(pc_out), 32'(exp_pc), "return");
    end
    do_op(VEC, '0);
    cmp(32'(pc_out), 32'(VECTOR_DEFAULT), "vector");
    do_op(RET, '0);
    cmp(32'(pc_out), 32'(exp_pc), "vector return");
    rnd = lfsr(rnd);
    op_pair(CALL, RET, rnd[10:0]);
    exp_pc = exp_pc + 13'h0001;
    cmp(32'(pc_out), 32'(exp_pc), "call then return");
    op_pair(VEC, RET, '0);
    cmp(32'(pc_out), 32'(exp_pc), "vector then return");
    bus(1'b0, OFF_PC_LATCH, 8'h00);
    cmp(rdv, 32'({3'h0, lat}), "latch kept");
    bus(1'b1, OFF_BANK, 8'h80);
    rnd = lfsr(rnd);
    ptr = rnd[7:0] | 8'h01;
    bus(1'b1, OFF_FSP, ptr);
    @(negedge core_clk);
    cmp(32'(ind_addr), 32'({1'b1, ptr}), "indirect address");
    bus(1'b1, OFF_INDIRECT, rnd[15:8]);
    bus(1'b0, OFF_INDIRECT, 8'h00);
    cmp(rdv, 32'(rnd[15:8]), "indirect data");
    cmp(32'(rd_cnt + 2 * wr_cnt), 32'h0000_0003, "indirect strobes");
    bus(1'b1, OFF_FSP, 8'h00);
    bus(1'b1, OFF_INDIRECT, 8'h5A);
    @(negedge core_clk);
    cmp(32'(wr_cnt), 32'h0000_0001, "self write");
    bus(1'b0, OFF_INDIRECT, 8'h00);
    cmp(rdv, 32'h0000_0000, "self read");
    cmp(32'(rd_cnt), 32'h0000_0001, "self read strobe");
    do_op(JUMP, 11'h7FF);
    cmp(32'(pc_out), 32'(paged(lat, 11'h7FF)), "jump before reset");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    cmp(32'(pc_out), 32'h0000_0000, "pc after second reset");
    bus(1'b1, 5'h14, 8'hFF);
    bus(1'b0, OFF_PC_LATCH, 8'h00);
    cmp(rdv, 32'h0000_0000, "unmapped write ignored");
    bus(1'b0, 5'h14, 8'h00);
    cmp(rdv, 32'h0000_0000, "unmapped read");
    report_and_stop;
  end
endmodule // pcs_core_bench
